// ### tpg_gpio.sv
/*
  Three-port GPIO block: two 8-bit ports and one 3-bit port (pins 3..1),
  each with an output latch and a write-only direction register.
  Assumes a simple strobe register port on I_MCLK, pins synchronised
  here, and a power-mode code from the system controller on I_MCLK.
*/
// Added by the designer: the plain strobed port.
// What this block does
// (R1) Wide ports: eight pins, bit n per pin
// (R2) Narrow port drives only pins 3..1
// (R3) Direction 1 drives latch; 0 makes input
// (R4) Output pins read back latched value
// (R5) Input pins read synchronised pin level
// (R6) Direction registers read as all ones
// (R7) Wide port registers reset to zero
// (R8) Narrow latch resets to upper nibble set
// (R9) Narrow direction resets to bits 7..4,0 set
// (R10) Reset and standby: all pins high impedance
// (R11) Sleep, subsleep, watch: pins hold state
// (R12) Active, subactive: pins follow registers
// (R13) Unimplemented narrow bits ignore writes
`timescale 1ns/1ps
module tpg_gpio #(
  parameter int unsigned WIDE_W = 8
) (
  // Clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_SYS_RST,
  // Register port
  input  wire logic [15:0]       I_ADDR,
  input  wire logic [7:0]        I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [7:0]        O_RDATA,
  // Power mode
  input  wire logic [2:0]        I_MODE,
  // Wide port one pins
  input  wire logic [WIDE_W-1:0] I_WIDE_PORT_ONE_PINS,
  output logic      [WIDE_W-1:0] O_WIDE_PORT_ONE_PINS,
  output logic      [WIDE_W-1:0] O_WIDE_PORT_ONE_PINS_OE,
  // Wide port two pins
  input  wire logic [WIDE_W-1:0] I_WIDE_PORT_TWO_PINS,
  output logic      [WIDE_W-1:0] O_WIDE_PORT_TWO_PINS,
  output logic      [WIDE_W-1:0] O_WIDE_PORT_TWO_PINS_OE,
  // Narrow port pins, bits 3..1
  input  wire logic [3:1]        I_NARROW_PORT_PINS,
  output logic      [3:1]        O_NARROW_PORT_PINS,
  output logic      [3:1]        O_NARROW_PORT_PINS_OE
);

  // Register state
  logic [7:0] p7_latch_q, p7_latch_d;
  logic [7:0] p8_latch_q, p8_latch_d;
  logic [7:0] pa_latch_q, pa_latch_d;
  logic [7:0] p7_dir_q, p7_dir_d;
  logic [7:0] p8_dir_q, p8_dir_d;
  logic [7:0] pa_dir_q, pa_dir_d;
  logic [7:0] rdata_q, rdata_d;

  // Synchronised pin levels as the read mux sees them
  logic [7:0] p7_s2_q, p8_s2_q, pa_s2_q;

  // Pin drive state
  tpg_pkg::tpg_pin_state_e pst;

  // Per-port views: index 0 port one, 1 port two, 2 narrow port
  logic [7:0] pin_in    [3];
  logic [7:0] pin_s1_q  [3];
  logic [7:0] pin_s2_q  [3];
  logic [7:0] drv_latch [3];
  logic [7:0] drv_dir   [3];
  logic [7:0] out_q     [3];
  logic [7:0] out_d     [3];
  logic [7:0] oe_q      [3];
  logic [7:0] oe_d      [3];

  assign pin_in[0] = 8'(I_WIDE_PORT_ONE_PINS);
  assign pin_in[1] = 8'(I_WIDE_PORT_TWO_PINS);
  assign pin_in[2] = {4'h0, I_NARROW_PORT_PINS, 1'b0};

  assign p7_s2_q = pin_s2_q[0];
  assign p8_s2_q = pin_s2_q[1];
  assign pa_s2_q = pin_s2_q[2];

  // Narrow port never drives its missing pins
  assign drv_latch[0] = p7_latch_q;
  assign drv_latch[1] = p8_latch_q;
  assign drv_latch[2] = pa_latch_q & tpg_pkg::NARROW_PIN_MASK; // [R2]
  assign drv_dir[0]   = p7_dir_q;
  assign drv_dir[1]   = p8_dir_q;
  assign drv_dir[2]   = pa_dir_q & tpg_pkg::NARROW_PIN_MASK;   // [R2]

  // Register writes
  always_comb begin
    p7_latch_d = p7_latch_q;
    p8_latch_d = p8_latch_q;
    pa_latch_d = pa_latch_q;
    p7_dir_d   = p7_dir_q;
    p8_dir_d   = p8_dir_q;
    pa_dir_d   = pa_dir_q;
    if (I_WR) begin
      case (I_ADDR)
        tpg_pkg::PORT7_OUTPUT_LATCH_OFS:     p7_latch_d = I_WDATA; // [R1]
        tpg_pkg::PORT8_OUTPUT_LATCH_OFS:     p8_latch_d = I_WDATA; // [R1]
        tpg_pkg::NARROW_PORT_OUTPUT_LATCH_OFS: begin
          pa_latch_d = (I_WDATA & tpg_pkg::NARROW_PIN_MASK)
                     | (tpg_pkg::NARROW_LATCH_RST & ~tpg_pkg::NARROW_PIN_MASK); // [R2] [R13]
        end
        tpg_pkg::PORT7_DIRECTION_SELECT_OFS: p7_dir_d = I_WDATA;
        tpg_pkg::PORT8_DIRECTION_SELECT_OFS: p8_dir_d = I_WDATA;
        tpg_pkg::NARROW_PORT_DIRECTION_SELECT_OFS: begin
          pa_dir_d = (I_WDATA & tpg_pkg::NARROW_PIN_MASK)
                   | (tpg_pkg::NARROW_DIR_RST & ~tpg_pkg::NARROW_PIN_MASK); // [R13]
        end
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_comb begin
    rdata_d = tpg_pkg::UNMAPPED_READ;
    if (I_RD) begin
      case (I_ADDR)
        tpg_pkg::PORT7_OUTPUT_LATCH_OFS:
          rdata_d = (p7_dir_q & p7_latch_q) | (~p7_dir_q & p7_s2_q); // [R4] [R5]
        tpg_pkg::PORT8_OUTPUT_LATCH_OFS:
          rdata_d = (p8_dir_q & p8_latch_q) | (~p8_dir_q & p8_s2_q); // [R4] [R5]
        tpg_pkg::NARROW_PORT_OUTPUT_LATCH_OFS:
          rdata_d = (~tpg_pkg::NARROW_PIN_MASK & pa_latch_q)
                  | (tpg_pkg::NARROW_PIN_MASK & pa_dir_q & pa_latch_q)
                  | (tpg_pkg::NARROW_PIN_MASK & ~pa_dir_q & pa_s2_q); // [R4] [R5] [R13]
        tpg_pkg::PORT7_DIRECTION_SELECT_OFS,
        tpg_pkg::PORT8_DIRECTION_SELECT_OFS,
        tpg_pkg::NARROW_PORT_DIRECTION_SELECT_OFS:
          rdata_d = tpg_pkg::DIR_READ_VALUE; // [R6]
        default: rdata_d = tpg_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Pin state from power mode
  always_comb begin
    case (I_MODE)
      tpg_pkg::MODE_ACTIVE, tpg_pkg::MODE_SUBACTIVE: pst = tpg_pkg::TPG_FUNCTIONAL; // [R12]
      tpg_pkg::MODE_SLEEP, tpg_pkg::MODE_SUBSLEEP,
      tpg_pkg::MODE_WATCH:                           pst = tpg_pkg::TPG_HOLD; // [R11]
      tpg_pkg::MODE_STANDBY:                         pst = tpg_pkg::TPG_HIGHZ; // [R10]
      default:                                       pst = tpg_pkg::TPG_HIGHZ;
    endcase
  end

  // Per-port synchroniser and pin drive
  for (genvar g = 0; g < 3; g++) begin : g_port
    // Two stages; only the second stage is read
    always_ff @(posedge I_MCLK) begin
      pin_s1_q[g] <= pin_in[g];
      pin_s2_q[g] <= pin_s1_q[g];
    end

    // Next drive value and enable from the power mode
    always_comb begin
      out_d[g] = out_q[g];
      oe_d[g]  = oe_q[g];
      case (pst)
        tpg_pkg::TPG_FUNCTIONAL: begin
          out_d[g] = drv_latch[g]; // [R3]
          oe_d[g]  = drv_dir[g];   // [R3]
        end
        tpg_pkg::TPG_HOLD: ; // [R11]
        tpg_pkg::TPG_HIGHZ: begin
          oe_d[g] = 8'h00; // [R10]
        end
        default: begin
          oe_d[g] = 8'h00;
        end
      endcase
    end

    always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
        out_q[g] <= 8'h00;
        oe_q[g]  <= 8'h00; // [R10]
      end else begin
        out_q[g] <= out_d[g];
        oe_q[g]  <= oe_d[g];
      end
    end
  end

  // Register group
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      p7_latch_q <= tpg_pkg::WIDE_LATCH_RST;   // [R7]
      p8_latch_q <= tpg_pkg::WIDE_LATCH_RST;   // [R7]
      p7_dir_q   <= tpg_pkg::WIDE_DIR_RST;     // [R7]
      p8_dir_q   <= tpg_pkg::WIDE_DIR_RST;     // [R7]
      pa_latch_q <= tpg_pkg::NARROW_LATCH_RST; // [R8]
      pa_dir_q   <= tpg_pkg::NARROW_DIR_RST;   // [R9]
    end else begin
      p7_latch_q <= p7_latch_d;
      p8_latch_q <= p8_latch_d;
      p7_dir_q   <= p7_dir_d;
      p8_dir_q   <= p8_dir_d;
      pa_latch_q <= pa_latch_d;
      pa_dir_q   <= pa_dir_d;
    end
  end

  // Read data group, zero outside the cycle after a read
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      rdata_q <= tpg_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA                 = rdata_q;
  assign O_WIDE_PORT_ONE_PINS    = out_q[0][WIDE_W-1:0];
  assign O_WIDE_PORT_ONE_PINS_OE = oe_q[0][WIDE_W-1:0];
  assign O_WIDE_PORT_TWO_PINS    = out_q[1][WIDE_W-1:0];
  assign O_WIDE_PORT_TWO_PINS_OE = oe_q[1][WIDE_W-1:0];
  assign O_NARROW_PORT_PINS      = out_q[2][3:1];
  assign O_NARROW_PORT_PINS_OE   = oe_q[2][3:1];

endmodule

// ### tpg_pkg.sv
/*
  Constants for the three-port GPIO block: register offsets, reset values,
  bus widths, the narrow pin mask and operating-mode encodings.
  Assumes a 16-bit register address space shared with other peripherals.
*/
package tpg_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [15:0] PORT7_OUTPUT_LATCH_OFS           = 16'hffda;
  localparam logic [15:0] PORT8_OUTPUT_LATCH_OFS           = 16'hffdb;
  localparam logic [15:0] NARROW_PORT_OUTPUT_LATCH_OFS     = 16'hffdd;
  localparam logic [15:0] PORT7_DIRECTION_SELECT_OFS       = 16'hffea;
  localparam logic [15:0] PORT8_DIRECTION_SELECT_OFS       = 16'hffeb;
  localparam logic [15:0] NARROW_PORT_DIRECTION_SELECT_OFS = 16'hffed;

  localparam logic [7:0] WIDE_LATCH_RST    = 8'h00;
  localparam logic [7:0] WIDE_DIR_RST      = 8'h00;
  localparam logic [7:0] NARROW_LATCH_RST  = 8'hf0;
  localparam logic [7:0] NARROW_DIR_RST    = 8'hf1;
  localparam logic [7:0] NARROW_PIN_MASK   = 8'h0e;
  localparam logic [7:0] DIR_READ_VALUE    = 8'hff;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // Operating mode encoding on the power-mode input
  localparam logic [2:0] MODE_ACTIVE    = 3'h0;
  localparam logic [2:0] MODE_SUBACTIVE = 3'h1;
  localparam logic [2:0] MODE_SLEEP     = 3'h2;
  localparam logic [2:0] MODE_SUBSLEEP  = 3'h3;
  localparam logic [2:0] MODE_WATCH     = 3'h4;
  localparam logic [2:0] MODE_STANDBY   = 3'h5;

  typedef enum logic [2:0] {
    TPG_FUNCTIONAL = 3'b001,
    TPG_HOLD       = 3'b010,
    TPG_HIGHZ      = 3'b100
  } tpg_pin_state_e;
endpackage

// ### tpg_gpio_assertions.sv
/* Checker for the three-port GPIO block, bound to its top module.
   Assumes one clock domain and I_MODE codes from the block package. */
`timescale 1ns/1ps
module tpg_gpio_chk #(
  parameter int unsigned WIDE_W = 8
) (
  // Clock, reset, register port, power mode
  input wire logic              I_MCLK,
  input wire logic              I_SYS_RST,
  input wire logic [15:0]       I_ADDR,
  input wire logic [7:0]        I_WDATA,
  input wire logic              I_WR,
  input wire logic              I_RD,
  input wire logic [7:0]        O_RDATA,
  input wire logic [2:0]        I_MODE,
  // Pin drive
  input wire logic [WIDE_W-1:0] O_WIDE_PORT_ONE_PINS,
  input wire logic [WIDE_W-1:0] O_WIDE_PORT_ONE_PINS_OE,
  input wire logic [WIDE_W-1:0] O_WIDE_PORT_TWO_PINS_OE,
  input wire logic [3:1]        O_NARROW_PORT_PINS,
  input wire logic [3:1]        O_NARROW_PORT_PINS_OE
);
  logic       any_oe;
  logic       hold_m;
  logic       act_m;
  logic [3:1] wd_n;
  assign any_oe = |{O_WIDE_PORT_ONE_PINS_OE, O_WIDE_PORT_TWO_PINS_OE, O_NARROW_PORT_PINS_OE};
  assign hold_m = I_MODE inside {3'h2, 3'h3, 3'h4};
  assign act_m  = I_MODE == 3'h0;
  assign wd_n   = I_WDATA[3:1];
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  property p_rst_hiz;
    disable iff (1'b0) I_SYS_RST |=> !any_oe;
  endproperty
  property p_stby_hiz;
    I_MODE == 3'h5 [*2] |=> !any_oe;
  endproperty
  property p_hold_one;
    hold_m [*2] |=> $stable(O_WIDE_PORT_ONE_PINS) && $stable(O_WIDE_PORT_ONE_PINS_OE);
  endproperty
  property p_hold_nar;
    hold_m [*2] |=> $stable(O_NARROW_PORT_PINS) && $stable(O_NARROW_PORT_PINS_OE);
  endproperty
  property p_dir_read;
    I_RD && I_ADDR inside {16'hffea, 16'hffeb, 16'hffed} |=> O_RDATA == 8'hff;
  endproperty
  property p_oe_one;
    I_WR && I_ADDR == 16'hffea && act_m ##1 act_m |=> O_WIDE_PORT_ONE_PINS_OE == $past(I_WDATA, 2);
  endproperty
  property p_oe_two;
    I_WR && I_ADDR == 16'hffeb && act_m ##1 act_m |=> O_WIDE_PORT_TWO_PINS_OE == $past(I_WDATA, 2);
  endproperty
  property p_oe_nar;
    I_WR && I_ADDR == 16'hffed && act_m ##1 act_m |=> O_NARROW_PORT_PINS_OE == $past(wd_n, 2);
  endproperty
  a_rst_hiz:  assert property (p_rst_hiz)  else $error("pins driven in reset");
  a_stby_hiz: assert property (p_stby_hiz) else $error("pins driven in standby");
  a_hold_one: assert property (p_hold_one) else $error("wide pins moved in hold");
  a_hold_nar: assert property (p_hold_nar) else $error("narrow pins moved in hold");
  a_dir_read: assert property (p_dir_read) else $error("direction read not ones");
  a_oe_one:   assert property (p_oe_one)   else $error("port one enable wrong");
  a_oe_two:   assert property (p_oe_two)   else $error("port two enable wrong");
  a_oe_nar:   assert property (p_oe_nar)   else $error("narrow enable wrong");
  c_dir_read: cover property (I_RD && I_ADDR == 16'hffed);
  c_stby:     cover property (I_MODE == 3'h5 [*2]);
  c_hold:     cover property (hold_m [*2]);
endmodule
bind tpg_gpio tpg_gpio_chk #(.WIDE_W(WIDE_W)) tpg_gpio_chk_i (.*);

// ### tpg_pins_model.sv
/* Board model for all nineteen port pins, one vector.
   Assumes the board drives its own level wherever the block releases. */
`timescale 1ns/1ps
module tpg_pins_model (
  // Block side
  input  wire logic [18:0] i_drive,
  input  wire logic [18:0] i_oe,
  // Board side
  input  wire logic [18:0] i_ext,
  output logic      [18:0] o_level
);
  assign o_level = (i_oe & i_drive) | (~i_oe & i_ext);
endmodule

// ### tpg_gpio_tb.sv
/* Self-checking bench for the three-port GPIO block.
   Assumes the pin model and the checker are compiled before it. */
`timescale 1ns/1ps
module tpg_gpio_tb;
  logic        clk = 0;
  logic        rst = 1;
  logic        wr = 0;
  logic        rd = 0;
  logic [15:0] adr = 0;
  logic [7:0]  wd = 0;
  logic [7:0]  rdat;
  logic [2:0]  md = 0;
  logic [18:0] oe;
  logic [18:0] po;
  logic [18:0] pin;
  logic [18:0] ext = 19'h5_a5c3;
  int          n_mismatch = 0;
  int          tests_run = 0;
  initial forever #12.5 clk = ~clk;
  tpg_gpio tpg_gpio_i (.I_MCLK(clk), .I_SYS_RST(rst), .I_ADDR(adr), .I_WDATA(wd),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_MODE(md),
    .I_WIDE_PORT_ONE_PINS(pin[7:0]), .O_WIDE_PORT_ONE_PINS(po[7:0]),
    .O_WIDE_PORT_ONE_PINS_OE(oe[7:0]), .I_WIDE_PORT_TWO_PINS(pin[15:8]),
    .O_WIDE_PORT_TWO_PINS(po[15:8]), .O_WIDE_PORT_TWO_PINS_OE(oe[15:8]),
    .I_NARROW_PORT_PINS(pin[18:16]), .O_NARROW_PORT_PINS(po[18:16]),
    .O_NARROW_PORT_PINS_OE(oe[18:16]));
  tpg_pins_model tpg_pins_model_i (.i_drive(po), .i_oe(oe), .i_ext(ext), .o_level(pin));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [18:0] s, logic [18:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(logic w, logic r, logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    adr <= a;
    wd <= d;
  endtask
  task automatic rd_chk(logic [15:0] a, logic [7:0] e);
    bus(0, 1, a, 0);
    bus(0, 0, 0, 0);
    #1 chk($sformatf("rd %h", a), rdat, e);
  endtask
  task automatic idle(int n);
    repeat (n) bus(0, 0, 0, 0);
  endtask
  task automatic t_reset;
    rd_chk(16'hffda, 8'hc3);
    rd_chk(16'hffdb, 8'ha5);
    rd_chk(16'hffdd, 8'hfa);
    rd_chk(16'hffed, 8'hff);
    chk("oe", oe, 19'h0);
    $display("end reset test");
  endtask
  task automatic t_out;
    bus(1, 0, 16'hffea, 8'hf0);
    bus(1, 0, 16'hffda, 8'ha5);
    bus(1, 0, 16'hffeb, 8'hff);
    bus(1, 0, 16'hffdb, 8'h3c);
    bus(1, 0, 16'hffed, 8'hff);
    bus(1, 0, 16'hffdd, 8'h0f);
    bus(1, 0, 16'h0000, 8'hff);
    idle(3);
    #1 chk("oe", oe, 19'h7_fff0);
    chk("drive", po & oe, 19'h7_3ca0);
    rd_chk(16'hffda, 8'ha3);
    rd_chk(16'hffdb, 8'h3c);
    rd_chk(16'hffdd, 8'hfe);
    rd_chk(16'hffea, 8'hff);
    rd_chk(16'h0000, 8'h00);
    $display("end output test");
  endtask
  task automatic t_modes;
    for (int m = 1; m < 8; m++) begin
      @(posedge clk) md <= 3'(m);
      bus(1, 0, 16'hffea, 8'h0f);
      idle(4);
      #1 chk("oe mode", oe, m >= 5 ? 19'h0 : (m == 1 ? 19'h7_ff0f : 19'h7_fff0));
      @(posedge clk) md <= 3'h0;
      bus(1, 0, 16'hffea, 8'hf0);
      idle(3);
      #1 chk("oe active", oe, 19'h7_fff0);
    end
    $display("end mode test");
  endtask
  task automatic t_rerun;
    @(posedge clk) rst <= 1;
    idle(2);
    #1 chk("oe rst", oe, 19'h0);
    @(posedge clk) rst <= 0;
    rd_chk(16'hffda, 8'hc3);
    $display("end second reset test");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    #1 chk("oe rst", oe, 19'h0);
    t_reset;
    t_out;
    t_modes;
    t_rerun;
    complete_run;
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule
